// ### verilog/rdp_pkg.sv
// constants and carrier types for the register instruction datapath
// assumes one clock domain shared with the issue logic and the bus
package rdp_pkg;
    // function codes
    localparam logic [7:0] F_XOR  = 8'h2c;
    localparam logic [7:0] F_AND  = 8'h2d;
    localparam logic [7:0] F_IOR  = 8'h2e;
    localparam logic [7:0] F_SHI  = 8'h30;
    localparam logic [7:0] F_SHR  = 8'h34;
    localparam logic [7:0] F_XMIT = 8'h38;
    localparam logic [7:0] F_ADDA = 8'h63;
    localparam logic [7:0] F_SUBA = 8'h67;
    localparam logic [7:0] F_INS  = 8'h6d;
    localparam logic [7:0] F_EXT  = 8'h6e;
    localparam logic [7:0] F_ENT  = 8'hbe;
    localparam logic [7:0] F_INC  = 8'hbf;
    localparam logic [7:0] F_HENT = 8'hcd;
    localparam logic [7:0] F_HINC = 8'hce;
    localparam logic [3:0] GRP_FP32 = 4'h4;
    localparam logic [3:0] GRP_FP64 = 4'h6;
    localparam logic [7:0] REG_ZERO = 8'h00;
    localparam logic [63:0] MZERO64 = 64'h8000_0000_0000_0000;
    localparam logic [31:0] MZERO32 = 32'h8000_0000;
    // field positions, vector index = 63 - bit number
    localparam int M_LSB = 48;
    localparam int N_LSB = 0;
    localparam int FLAG_DIV = 63 - 41;
    localparam int FLAG_OVF = 63 - 42;
    localparam int FLAG_MZ  = 63 - 43;
    localparam int FLAG_IND = 63 - 46;
    // bus map
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_FLGHI = 8'h04;
    localparam logic [7:0] A_FLGLO = 8'h08;
    localparam logic [7:0] A_COUNT = 8'h0c;
    localparam logic [7:0] A_RFSEL = 8'h10;
    localparam logic [7:0] A_RFHI  = 8'h14;
    localparam logic [7:0] A_RFLO  = 8'h18;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    typedef enum {RK_UPPER, RK_LOWER, RK_NORM, RK_SIGNIF} rdp_kind_t;
    typedef struct packed {
        logic [7:0]  func;
        logic [7:0]  r;
        logic [7:0]  s;
        logic [7:0]  t;
        logic [31:0] tail;
    } rdp_instr_t;
    typedef struct packed {
        logic [63:0] upper;
        logic [63:0] lower;
        logic [63:0] norm;
        logic [63:0] signif;
        logic [3:0]  flags;   // divide, overflow, machine zero, indefinite
    } rdp_fpres_t;
endpackage : rdp_pkg

// ### verilog/rdp_datapath.sv
// register file and one-cycle execute stage for index and register ops
// assumes the issue logic holds instr while issueValid waits for ready,
// and an outside arithmetic unit answers fp operands in the same cycle
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
module rdp_datapath #(
    parameter int RF_DEPTH = 256
) (
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire logic               issueValid,
    output logic                    issueReady,
    input  wire rdp_pkg::rdp_instr_t instr,
    output logic [63:0]             fpOpA,
    output logic [63:0]             fpOpB,
    input  wire rdp_pkg::rdp_fpres_t fpRes,
    output logic                    doneQ,
    output logic [63:0]             resultQ,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);
    logic [63:0] rf_q [RF_DEPTH];
    logic [63:0] flags_q;
    logic [31:0] ctrl_q;
    logic [31:0] count_q;
    logic [7:0]  rfSel_q;
    logic        fire;
    logic [63:0] opR;
    logic [63:0] opS;
    logic [63:0] oldT;
    logic [7:0]  dst;
    logic [63:0] res;
    logic        wr;
    logic        isFp;
    logic        fp32;
    logic [7:0]  cnt;
    logic [5:0]  m;
    logic [5:0]  n;
    logic [6:0]  pos;
    logic [63:0] mask;
    logic [3:0]  fpFlags;
    logic [63:0] fpPick;
    rdp_pkg::rdp_kind_t kind;

    // machine zero for register 00, otherwise the stored word
    function automatic logic [63:0] src(input logic [7:0] sel, input logic w32,
                                        input logic [63:0] val);
        logic [63:0] z;
        z = w32 ? {32'h0, rdp_pkg::MZERO32} : rdp_pkg::MZERO64;
        if (sel == rdp_pkg::REG_ZERO)
            return z;
        return w32 ? {32'h0, val[31:0]} : val;
    endfunction : src

    assign issueReady = ctrl_q[0];
    assign fire = issueValid && issueReady;
    assign isFp = (instr.func[7:4] == rdp_pkg::GRP_FP32 || instr.func[7:4] == rdp_pkg::GRP_FP64)
                  && instr.func != rdp_pkg::F_ADDA && instr.func != rdp_pkg::F_SUBA
                  && instr.func != rdp_pkg::F_INS && instr.func != rdp_pkg::F_EXT;
    assign fp32 = isFp && instr.func[7:4] == rdp_pkg::GRP_FP32;
    assign opR = src(instr.r, fp32, rf_q[instr.r]);
    assign opS = src(instr.s, fp32, rf_q[instr.s]);
    // the immediate forms name their register in R, all others in T
    assign dst = (instr.func == rdp_pkg::F_ENT || instr.func == rdp_pkg::F_INC
                  || instr.func == rdp_pkg::F_HENT || instr.func == rdp_pkg::F_HINC)
                 ? instr.r : instr.t;
    assign oldT = rf_q[dst];
    assign fpOpA = opR;
    assign fpOpB = opS;
    assign kind = rdp_pkg::rdp_kind_t'(instr.func[1:0]);
    // shift count from the S field or from the low byte of register S
    assign cnt = (instr.func == rdp_pkg::F_SHR) ? opS[7:0] : instr.s;
    assign m = opS[rdp_pkg::M_LSB +: 6];
    assign n = opS[rdp_pkg::N_LSB +: 6];
    // out-of-range m and n simply wrap; nothing guards them
    assign pos = 7'(7'd64 - {1'b0, n} - {1'b0, m});
    assign mask = (64'h1 << m) - 64'h1;

    always_comb
    begin
        case (kind)
            rdp_pkg::RK_UPPER: fpPick = fpRes.upper;
            rdp_pkg::RK_LOWER: fpPick = fpRes.lower;
            rdp_pkg::RK_NORM:  fpPick = fpRes.norm;
            default:           fpPick = fpRes.signif;
        endcase
    end

    // every result is built whole; F_INC, F_HINC, F_XMIT and F_INS keep bits of the old destination
    always_comb
    begin
        res = 64'h0;
        wr = 1'b1;
        fpFlags = 4'h0;
        case (instr.func)
            rdp_pkg::F_HENT: res = {40'h0, instr.r, instr.s, instr.t};
            rdp_pkg::F_HINC: res = {32'h0, oldT[31:24],
                                    oldT[23:0] + {instr.r, instr.s, instr.t}};
            rdp_pkg::F_ENT:  res = {16'h0, instr.s, instr.t, instr.tail};
            rdp_pkg::F_INC:  res = {oldT[63:48],
                                    oldT[47:0] + {instr.s, instr.t, instr.tail}};
            rdp_pkg::F_XMIT: res = {opR[63:48], oldT[47:0]};
            rdp_pkg::F_XOR:  res = opR ^ opS;
            rdp_pkg::F_AND:  res = opR & opS;
            rdp_pkg::F_IOR:  res = opR | opS;
            rdp_pkg::F_SHI, rdp_pkg::F_SHR:
            begin
                // counts 40-c0 fall into one of the two arms; undefined anyway
                if (!cnt[7])
                    res = 64'(({opR, opR} << cnt[5:0]) >> 64);
                else
                    res = 64'($signed(opR) >>> 6'(-cnt));
            end
            rdp_pkg::F_ADDA: res = {opR[63:48], opR[47:0] + opS[47:0]};
            rdp_pkg::F_SUBA: res = {opR[63:48], opR[47:0] - opS[47:0]};
            rdp_pkg::F_INS:  res = (oldT & ~(mask << pos))
                                   | ((opR & mask) << pos);
            rdp_pkg::F_EXT:  res = (opR >> pos) & mask;
            default:
            begin
                if (isFp)
                begin
                    res = fp32 ? {32'h0, fpPick[31:0]} : fpPick;
                    fpFlags = fpRes.flags;
                end
                else
                    wr = 1'b0;
            end
        endcase
    end

    // register 00 is never written
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < RF_DEPTH; i++)
                rf_q[i] <= 64'h0;
        end
        else if (fire && wr && dst != rdp_pkg::REG_ZERO)
            rf_q[dst] <= res;
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            doneQ <= 1'b0;
            resultQ <= 64'h0;
            count_q <= 32'h0;
        end
        else
        begin
            doneQ <= fire;
            if (fire)
            begin
                resultQ <= res;
                count_q <= count_q + 32'h1;
            end
        end
    end

    // bus slave
    logic        awHeld;
    logic        wHeld;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic        doWrite;
    logic [63:0] flagSet;
    logic [63:0] flagClr;
    logic [63:0] rfView;

    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign rfView = rf_q[rfSel_q];

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 8'h0;
            wData <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rdp_pkg::RESP_OK;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
            end
            if (doWrite)
            begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awAddr == rdp_pkg::A_CTRL || awAddr == rdp_pkg::A_FLGHI
                    || awAddr == rdp_pkg::A_FLGLO || awAddr == rdp_pkg::A_RFSEL)
                    s_axi_bresp <= rdp_pkg::RESP_OK;
                else
                    s_axi_bresp <= rdp_pkg::RESP_ERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ctrl keeps bit 0 and the selector the low byte, whatever the strobes; strobes gate only the flag clear
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            ctrl_q <= rdp_pkg::CTRL_RST;
            rfSel_q <= 8'h0;
        end
        else if (doWrite && awAddr == rdp_pkg::A_CTRL)
            ctrl_q <= {31'h0, wData[0]};
        else if (doWrite && awAddr == rdp_pkg::A_RFSEL)
            rfSel_q <= wData[7:0];
    end

    always_comb
    begin
        flagSet = 64'h0;
        flagSet[rdp_pkg::FLAG_DIV] = fire && fpFlags[3];
        flagSet[rdp_pkg::FLAG_OVF] = fire && fpFlags[2];
        flagSet[rdp_pkg::FLAG_MZ] = fire && fpFlags[1];
        flagSet[rdp_pkg::FLAG_IND] = fire && fpFlags[0];
        flagClr = 64'h0;
        for (int b = 0; b < 4; b++)
        begin
            if (doWrite && awAddr == rdp_pkg::A_FLGHI && s_axi_wstrb[b])
                flagClr[32 + 8 * b +: 8] = wData[8 * b +: 8];
            if (doWrite && awAddr == rdp_pkg::A_FLGLO && s_axi_wstrb[b])
                flagClr[8 * b +: 8] = wData[8 * b +: 8];
        end
    end

    // a new flag beats a clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (!nrst)
            flags_q <= 64'h0;
        else
            flags_q <= (flags_q & ~flagClr) | flagSet;
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= rdp_pkg::RESP_OK;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rdp_pkg::RESP_OK;
            if (s_axi_araddr == rdp_pkg::A_CTRL)
                s_axi_rdata <= ctrl_q;
            else if (s_axi_araddr == rdp_pkg::A_FLGHI)
                s_axi_rdata <= flags_q[63:32];
            else if (s_axi_araddr == rdp_pkg::A_FLGLO)
                s_axi_rdata <= flags_q[31:0];
            else if (s_axi_araddr == rdp_pkg::A_COUNT)
                s_axi_rdata <= count_q;
            else if (s_axi_araddr == rdp_pkg::A_RFSEL)
                s_axi_rdata <= {24'h0, rfSel_q};
            else if (s_axi_araddr == rdp_pkg::A_RFHI)
                s_axi_rdata <= rfView[63:32];
            else if (s_axi_araddr == rdp_pkg::A_RFLO)
                s_axi_rdata <= rfView[31:0];
            else
            begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= rdp_pkg::RESP_ERR;
            end
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // checks
    property p_hent;
        @(posedge clock) disable iff (!nrst)
        fire && instr.func == rdp_pkg::F_HENT
        |=> doneQ && resultQ == {40'h0, $past(instr.r), $past(instr.s), $past(instr.t)};
    endproperty
    a_hent: assert property (p_hent) else $error("half enter wrong");
    property p_hinc;
        @(posedge clock) disable iff (!nrst)
        fire && instr.func == rdp_pkg::F_HINC |=> resultQ[31:24] == $past(oldT[31:24])
        && resultQ[63:32] == 32'h0;
    endproperty
    a_hinc: assert property (p_hinc) else $error("half increase top bits");
    property p_ent;
        @(posedge clock) disable iff (!nrst)
        fire && instr.func == rdp_pkg::F_ENT && instr.r != rdp_pkg::REG_ZERO
        ##1 1'b1 |-> rf_q[$past(instr.r)][63:48] == 16'h0
        && rf_q[$past(instr.r)][47:0] == $past(instr[47:0]);
    endproperty
    a_ent: assert property (p_ent) else $error("enter 48 wrong");
    property p_inc;
        @(posedge clock) disable iff (!nrst)
        fire && instr.func == rdp_pkg::F_INC |=> resultQ[63:48] == $past(oldT[63:48]);
    endproperty
    a_inc: assert property (p_inc) else $error("increase 48 top changed");
    property p_xmit;
        @(posedge clock) disable iff (!nrst)
        fire && instr.func == rdp_pkg::F_XMIT
        |=> resultQ == {$past(opR[63:48]), $past(oldT[47:0])};
    endproperty
    a_xmit: assert property (p_xmit) else $error("transmit upper wrong");
    property p_zsrc;
        @(posedge clock) disable iff (!nrst)
        fire && instr.func == rdp_pkg::F_IOR && instr.r == rdp_pkg::REG_ZERO
        && instr.s == rdp_pkg::REG_ZERO |=> resultQ == rdp_pkg::MZERO64;
    endproperty
    a_zsrc: assert property (p_zsrc) else $error("register zero not machine zero");
    property p_zdst;
        @(posedge clock) disable iff (!nrst)
        ##1 rf_q[0] == 64'h0;
    endproperty
    a_zdst: assert property (p_zdst) else $error("register zero written");
    property p_rot0;
        @(posedge clock) disable iff (!nrst)
        fire && instr.func == rdp_pkg::F_SHI && instr.s == 8'h00 |=> resultQ == $past(opR);
    endproperty
    a_rot0: assert property (p_rot0) else $error("zero rotate altered");
    property p_shflag;
        @(posedge clock) disable iff (!nrst)
        fire && (instr.func == rdp_pkg::F_SHI || instr.func == rdp_pkg::F_SHR)
        && !(doWrite && (awAddr == rdp_pkg::A_FLGHI || awAddr == rdp_pkg::A_FLGLO))
        |=> $stable(flags_q);
    endproperty
    a_shflag: assert property (p_shflag) else $error("shift touched flags");
    c_shr: cover property (@(posedge clock) fire && instr.func == rdp_pkg::F_SHI && instr.s[7]);
    c_ins: cover property (@(posedge clock) fire && instr.func == rdp_pkg::F_INS);
    c_fp: cover property (@(posedge clock) fire && isFp && fpRes.flags != 4'h0);
endmodule : rdp_datapath

// ### verif/rdp_fp_model.sv
// behavioural arithmetic unit facing rdp_datapath's fp operand port
// assumes the bench commands the data flags; answers in the same cycle
module rdp_fp_model (
    input  wire logic [63:0]    opA,
    input  wire logic [63:0]    opB,
    input  wire logic [3:0]     flagsCmd,
    output rdp_pkg::rdp_fpres_t res
);
    timeunit 1ns;
    timeprecision 1ps;
    // plain integer stand-ins: enough to tell the four result kinds apart
    // one driver for the whole word: upper, lower, norm, signif, flags
    assign res = {opA + opB, opA ^ opB, opA - opB, opA | opB, flagsCmd};
endmodule : rdp_fp_model

// ### verif/rdp_datapath_tb.sv
// self-checking bench for rdp_datapath with the arithmetic unit model
// assumes 100 MHz clock, synchronous active-low reset, AXI4-Lite master here
module rdp_datapath_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, nrst, issueValid, doneQ, issueReady;
    rdp_pkg::rdp_instr_t instr;
    rdp_pkg::rdp_fpres_t fpRes;
    logic [63:0] fpOpA, fpOpB, resultQ;
    logic [3:0] fpFlags, s_axi_wstrb;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int errors, numChecks, nIssued, cycles;
    rdp_datapath dut (.clock(clock), .nrst(nrst), .issueValid(issueValid),
        .issueReady(issueReady), .instr(instr), .fpOpA(fpOpA), .fpOpB(fpOpB),
        .fpRes(fpRes), .doneQ(doneQ), .resultQ(resultQ), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    rdp_fp_model fpu (.opA(fpOpA), .opB(fpOpB), .flagsCmd(fpFlags), .res(fpRes));
    always #5 clock = ~clock;
    task automatic final_report();
        if (errors == 0 && numChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    // a hang costs a mismatch; the full run needs about 250 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            $display("unexpected at %0t: timed out", $time);
            final_report();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        numChecks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic iss(input logic [7:0] f, r, s, t, input logic [31:0] tl = 32'h0);
        @(posedge clock);
        instr      <= '{f, r, s, t, tl};
        issueValid <= 1'b1;
        @(posedge clock);
        issueValid <= 1'b0;
        nIssued++;
        @(negedge clock);
        chk({63'h0, doneQ}, 64'h1, "done pulse");
    endtask : iss
    task automatic wide(input logic [7:0] f, r, input logic [47:0] imm);
        iss(f, r, imm[47:40], imm[39:32], imm[31:0]);
    endtask : wide
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d   = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask : axr
    task automatic rdreg(input logic [7:0] idx, input logic [63:0] exp);
        logic [31:0] hi, lo;
        logic [1:0] rsp;
        axw(rdp_pkg::A_RFSEL, {24'h0, idx}, rsp);
        axr(rdp_pkg::A_RFHI, hi, rsp);
        axr(rdp_pkg::A_RFLO, lo, rsp);
        chk({hi, lo}, exp, "entry readback");
    endtask : rdreg
    task automatic rdword(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] rsp;
        axr(a, d, rsp);
        chk({30'h0, rsp, d}, {30'h0, er, exp}, "bus read");
    endtask : rdword
    task automatic t_reset();
        @(negedge clock);
        chk({62'h0, issueReady, doneQ}, 64'h2, "reset handshake");
        chk(resultQ, 64'h0, "reset result");
        rdword(rdp_pkg::A_CTRL, rdp_pkg::CTRL_RST, rdp_pkg::RESP_OK);
        rdreg(8'h7f, 64'h0);
    endtask : t_reset
    task automatic t_wide();
        wide(rdp_pkg::F_ENT, 8'h10, 48'hffff_ffff_ffff);
        chk(resultQ, 64'h0000_ffff_ffff_ffff, "enter");
        iss(rdp_pkg::F_SHI, 8'h10, 8'h10, 8'h11);
        chk(resultQ, 64'hffff_ffff_ffff_0000, "rotate 16");
        wide(rdp_pkg::F_INC, 8'h11, 48'h0000_0001_0000);
        chk(resultQ, 64'hffff_0000_0000_0000, "increase wrap");
        wide(rdp_pkg::F_ENT, 8'h11, 48'h1234_5678_9abc);
        chk(resultQ, 64'h0000_1234_5678_9abc, "enter clears");
        rdreg(8'h11, 64'h0000_1234_5678_9abc);
        rdreg(8'h10, 64'h0000_ffff_ffff_ffff);
        // short form: the 24-bit immediate shares its top byte with the register number
        wide(rdp_pkg::F_ENT, 8'hff, 48'h0000_1200_0100);
        iss(rdp_pkg::F_HINC, 8'hff, 8'h00, 8'h01);
        chk(resultQ, 64'h0000_0000_12ff_0101, "half increase");
        iss(rdp_pkg::F_HINC, 8'hff, 8'h00, 8'h01);
        chk(resultQ, 64'h0000_0000_12fe_0102, "half carry");
        iss(rdp_pkg::F_HENT, 8'hff, 8'h00, 8'h07);
        rdreg(8'hff, 64'h0000_0000_00ff_0007);
    endtask : t_wide
    task automatic t_logic();
        iss(rdp_pkg::F_IOR, 8'h00, 8'h11, 8'h20);
        chk(resultQ, 64'h8000_1234_5678_9abc, "or zero src");
        iss(rdp_pkg::F_AND, 8'h11, 8'h20, 8'h21);
        chk(resultQ, 64'h0000_1234_5678_9abc, "and");
        iss(rdp_pkg::F_XOR, 8'h20, 8'h00, 8'h00);
        chk(resultQ, 64'h0000_1234_5678_9abc, "xor");
        rdreg(8'h00, 64'h0);
        rdreg(8'h20, 64'h8000_1234_5678_9abc);
    endtask : t_logic
    task automatic t_shift();
        logic [7:0] cnt [4] = '{8'h00, 8'h3f, 8'hfe, 8'hc1};
        logic [63:0] exp [4] = '{64'h8000_1234_5678_9abc, 64'h4000_091a_2b3c_4d5e,
                                 64'he000_048d_159e_26af, 64'hffff_ffff_ffff_ffff};
        for (int i = 0; i < 4; i++)
        begin
            iss(rdp_pkg::F_SHI, 8'h20, cnt[i], 8'h21);
            chk(resultQ, exp[i], "shift field");
            wide(rdp_pkg::F_ENT, 8'h30, {40'hab_cdef_0123, cnt[i]});
            iss(rdp_pkg::F_SHR, 8'h20, 8'h30, 8'h22);
            chk(resultQ, exp[i], "shift reg");
        end
        iss(rdp_pkg::F_SHI, 8'h00, 8'hfe, 8'h22);
        chk(resultQ, 64'he000_0000_0000_0000, "shift zero src");
        rdword(rdp_pkg::A_FLGLO, 32'h0, rdp_pkg::RESP_OK);
    endtask : t_shift
    task automatic t_field();
        logic [7:0] f [4] = '{rdp_pkg::F_INS, rdp_pkg::F_INS, rdp_pkg::F_EXT, rdp_pkg::F_EXT};
        logic [5:0] m [4] = '{6'd8, 6'd16, 6'd16, 6'd12};
        logic [5:0] n [4] = '{6'd4, 6'd48, 6'd0, 6'd16};
        logic [63:0] exp [4] = '{64'h0bc0_ffff_ffff_ffff, 64'h0bc0_ffff_ffff_9abc,
                                 64'h0000_0000_0000_8000, 64'h0000_0000_0000_0123};
        wide(rdp_pkg::F_ENT, 8'h40, 48'hffff_ffff_ffff);
        for (int i = 0; i < 4; i++)
        begin
            // rotating by 22 lands n and m in their fields, spare bits stay zero
            wide(rdp_pkg::F_ENT, 8'h31, {n[i], 10'h0, m[i], 26'h0});
            iss(rdp_pkg::F_SHI, 8'h31, 8'h16, 8'h31);
            iss(f[i], 8'h20, 8'h31, 8'h40);
            chk(resultQ, exp[i], "bit field");
        end
    endtask : t_field
    task automatic t_addr();
        iss(rdp_pkg::F_XMIT, 8'h20, 8'h00, 8'h40);
        chk(resultQ, 64'h8000_0000_0000_0123, "upper copy");
        iss(rdp_pkg::F_ADDA, 8'h20, 8'h11, 8'h41);
        chk(resultQ, 64'h8000_2468_acf1_3578, "address add");
        iss(rdp_pkg::F_SUBA, 8'h20, 8'h41, 8'h42);
        chk(resultQ, 64'h8000_edcb_a987_6544, "address sub");
    endtask : t_addr
    task automatic t_fp();
        logic [7:0] f [4] = '{8'h60, 8'h61, 8'h62, 8'h43};
        logic [63:0] exp [4] = '{64'h0000_1234_5678_9bdf, 64'h0000_1234_5678_9b9f,
                                 64'h0000_1234_5678_9999, 64'h0000_0000_5678_9bbf};
        logic [1:0] rsp;
        for (int i = 0; i < 4; i++)
        begin
            iss(f[i], 8'h20, 8'h40, 8'h50);
            chk(resultQ, exp[i], "fp kind");
        end
        @(posedge clock);
        fpFlags <= 4'b1010;
        iss(8'h40, 8'h00, 8'h40, 8'h00);
        chk(resultQ, 64'h0000_0000_8000_0123, "fp zero src");
        rdreg(8'h00, 64'h0);
        rdword(rdp_pkg::A_FLGLO, 32'h0050_0000, rdp_pkg::RESP_OK);
        axw(rdp_pkg::A_FLGLO, 32'h0040_0000, rsp);
        fpFlags <= 4'b0101;
        iss(8'h60, 8'h20, 8'h40, 8'h00);
        fpFlags <= 4'b0000;
        rdword(rdp_pkg::A_FLGLO, 32'h0032_0000, rdp_pkg::RESP_OK);
        rdword(rdp_pkg::A_FLGHI, 32'h0, rdp_pkg::RESP_OK);
    endtask : t_fp
    task automatic t_bus();
        logic [1:0] rsp;
        rdword(rdp_pkg::A_COUNT, nIssued, rdp_pkg::RESP_OK);
        axw(rdp_pkg::A_COUNT, 32'h5, rsp);
        chk({62'h0, rsp}, {62'h0, rdp_pkg::RESP_ERR}, "read-only write");
        rdword(8'h1c, 32'h0, rdp_pkg::RESP_ERR);
        axw(rdp_pkg::A_CTRL, 32'h0, rsp);
        @(posedge clock);
        instr      <= '{rdp_pkg::F_XOR, 8'h20, 8'h20, 8'h60, 32'h0};
        issueValid <= 1'b1;
        repeat (3) @(negedge clock);
        chk({62'h0, issueReady, doneQ}, 64'h0, "disabled issue");
        @(posedge clock);
        issueValid <= 1'b0;
        rdword(rdp_pkg::A_COUNT, nIssued, rdp_pkg::RESP_OK);
        axw(rdp_pkg::A_CTRL, 32'h1, rsp);
        iss(rdp_pkg::F_XOR, 8'h20, 8'h20, 8'h60);
        chk(resultQ, 64'h0, "reenabled");
    endtask : t_bus
    initial
    begin
        {clock, nrst, issueValid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        instr       = '0;
        fpFlags     = 4'h0;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_wide();
        t_logic();
        t_shift();
        t_field();
        t_addr();
        t_fp();
        t_bus();
        final_report();
    end
endmodule : rdp_datapath_tb
